// *** pxp_pkg.sv ***
// constants and types for the extended page two register bank
package pxp_pkg;
  // management register numbers
  localparam logic [4:0] ADDR_PAGE_SEL = 5'h1f;
  localparam logic [4:0] ADDR_LPI_CTRL = 5'h11;
  localparam logic [4:0] ADDR_VARIANT = 5'h12;
  localparam logic [4:0] ADDR_ENTROPY = 5'h13;
  localparam logic [4:0] ADDR_EV_MASK = 5'h1c;
  localparam logic [4:0] ADDR_EV_PEND = 5'h1d;
  localparam logic [4:0] ADDR_PAGED_LO = 5'h10;
  localparam logic [4:0] ADDR_PAGED_HI = 5'h1e;
  // page select values
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  // low power control field positions
  localparam int LPC_EN_10TE = 15;
  localparam int LPC_IND_UNIDIR = 14;
  localparam int LPC_INV_HI = 13;
  localparam int LPC_INV_LO = 10;
  localparam int LPC_LINK_UP = 8;
  localparam int LPC_LPI_1G = 7;
  localparam int LPC_LPI_100 = 6;
  localparam int LPC_FORCE_1G = 5;
  localparam int LPC_FORCE_TX_LPI = 4;
  localparam int LPC_INH_100_TX = 3;
  localparam int LPC_INH_100_RX = 2;
  localparam int LPC_INH_1G_TX = 1;
  localparam int LPC_INH_1G_RX = 0;
  // low power control writable bits: 15:10 and 5:0
  localparam logic [15:0] LPC_RW_MASK = 16'hfc3f;
  localparam logic [15:0] LPC_RESET = 16'h0000;
  // variant capability field positions
  localparam int VAR_INDUSTRIAL = 15;
  localparam int VAR_QUAD = 14;
  localparam int VAR_PTP = 13;
  localparam int VAR_SECURE = 12;
  localparam int VAR_DUAL_MEDIA = 10;
  localparam int VAR_HI_PREC = 9;
  localparam int VAR_KEY256 = 8;
  // event field layout
  localparam int EV_COUNT = 11;
  localparam logic [15:0] EV_MASK_RESET = 16'h0000;
  localparam logic [15:0] ENTROPY_SEED = 16'hace1;
  // speed select code in control register 0 bits {6,13} for gigabit
  localparam logic [1:0] SPEED_SEL_1G = 2'b10;

  typedef struct packed {
    logic mode_1g;
    logic mode_100;
    logic mac_tx_lpi;
    logic line_rx_lpi;
  } pxp_lpi_in_t;

  typedef struct packed {
    logic line_tx_lpi;
    logic tx_from_generator;
    logic mac_rx_lpi;
  } pxp_lpi_out_t;

  typedef struct packed {
    logic link_up;
    logic lpi_active_1g;
    logic lpi_active_100;
  } pxp_link_stat_t;
endpackage

// *** pxp_regs.sv ***
// extended page two register bank with lpi control and event flags
//
// Functional notes
// - page two reached after writing 0x0002 to 31
// - writing 0x0000 to 31 returns main set
// - bit 15 enables energy efficient 10 Mb/s
// - bit 14 keeps indicators alive in unidirectional
// - bits 13:10 invert indicator groups, default low
// - read-only link up and lpi active flags
// - bit 4 sends generated lpi, ignores mac
// - bit 3 blocks 100M line transmit lpi
// - bit 2 blocks 100M mac receive lpi
// - bit 1 blocks gigabit line transmit lpi
// - bit 0 blocks gigabit mac receive lpi
// - identification reports read-only capability flags
// - bit 15 reports industrial temperature variant
// - bits 7:0 report bcd variant suffix
// - read-only random entropy word
// - mask enables bits 10:0, reserved 15:11
// - event positions 10 down to 3
// - event positions 2 down to 0
// - pending bits read-only, self clearing
//
// Local design decision: the plain strobed port.
module pxp_regs #(
  parameter logic IS_INDUSTRIAL = 1'b0,
  parameter logic IS_QUAD = 1'b0,
  parameter logic HAS_PTP = 1'b1,
  parameter logic HAS_SECURE = 1'b1,
  parameter logic HAS_DUAL_MEDIA = 1'b1,
  parameter logic HAS_HI_PREC = 1'b0,
  parameter logic HAS_KEY256 = 1'b1,
  // variant suffix in bcd; value is arbitrary
  parameter logic [7:0] VARIANT_BCD = 8'h42,
  parameter int IND_GROUPS = 4,
  parameter int IND_PER_GROUP = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic soft_reset,
  // management register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rhit,
  output logic [15:0] page_sel,
  // low power idle paths
  input wire pxp_pkg::pxp_lpi_in_t lpi_in,
  output pxp_pkg::pxp_lpi_out_t lpi_out,
  // link state from the transceiver core
  input wire pxp_pkg::pxp_link_stat_t link_stat,
  input wire logic [1:0] ctrl0_speed_sel,
  output logic en_10te,
  output logic force_1g_no_ms,
  // indicators
  input wire logic [IND_GROUPS*IND_PER_GROUP-1:0] ind_req,
  input wire logic [IND_GROUPS-1:0] serial_ind_req,
  input wire logic fiber_unidir,
  output logic [IND_GROUPS*IND_PER_GROUP-1:0] indicator_outputs,
  output logic [IND_GROUPS-1:0] serial_ind,
  // events and entropy
  input wire logic [pxp_pkg::EV_COUNT-1:0] ev_in,
  input wire logic noise_pin,
  output logic irq
);
  localparam int NIND = IND_GROUPS * IND_PER_GROUP;

  logic rst_sync1;
  logic rst_n;
  logic [15:0] page;
  logic [15:0] lpc;
  logic [15:0] ev_mask;
  logic [pxp_pkg::EV_COUNT-1:0] ev_pend;
  logic [15:0] entropy;
  logic noise_s1;
  logic noise_s2;
  pxp_pkg::pxp_link_stat_t stat_q;
  logic on_page2;
  logic paged_addr;
  logic [15:0] variant_word;
  logic [15:0] next_rdata;
  logic next_rhit;
  logic [IND_GROUPS-1:0] ind_inv;
  logic ind_enable;
  logic wr_lpc;
  logic wr_mask;
  logic rd_pend;
  logic entropy_fb;

  // reset release through two flops: assertion is immediate, release
  // waits two edges so no flop leaves reset on a runt edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // noise pin synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      noise_s1 <= 1'b0;
      noise_s2 <= 1'b0;
    end else begin
      noise_s1 <= noise_pin;
      noise_s2 <= noise_s1;
    end
  end

  // page decode: only 16..30 follow the page, 0..15 never
  assign paged_addr = (reg_addr >= pxp_pkg::ADDR_PAGED_LO) &&
                      (reg_addr <= pxp_pkg::ADDR_PAGED_HI);
  assign on_page2 = paged_addr && (page == pxp_pkg::PAGE_EXT2);
  assign wr_lpc = reg_wr && on_page2 && (reg_addr == pxp_pkg::ADDR_LPI_CTRL);
  assign wr_mask = reg_wr && on_page2 && (reg_addr == pxp_pkg::ADDR_EV_MASK);
  assign rd_pend = reg_rd && on_page2 && (reg_addr == pxp_pkg::ADDR_EV_PEND);

  // page select register; 0x0000 gives the main set back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page <= pxp_pkg::PAGE_MAIN;
    end else if (soft_reset) begin
      page <= pxp_pkg::PAGE_MAIN;
    end else if (reg_wr && reg_addr == pxp_pkg::ADDR_PAGE_SEL) begin
      page <= reg_wdata;
    end
  end

  // sticky control bits: survive soft reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lpc <= pxp_pkg::LPC_RESET;
    end else if (wr_lpc) begin
      lpc <= reg_wdata & pxp_pkg::LPC_RW_MASK;
    end
  end

  // event mask, all sixteen bits stored, sticky
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_mask <= pxp_pkg::EV_MASK_RESET;
    end else if (wr_mask) begin
      ev_mask <= reg_wdata;
    end
  end

  // pending flags: a new event wins over the read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_pend <= '0;
    end else if (soft_reset) begin
      ev_pend <= ev_in;
    end else if (rd_pend) begin
      ev_pend <= ev_in;
    end else begin
      ev_pend <= ev_pend | ev_in;
    end
  end

  // interrupt level: pending events that the mask lets through
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_pend & ev_mask[pxp_pkg::EV_COUNT-1:0]);
    end
  end

  // link status snapshots
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= link_stat;
    end
  end

  // free running lfsr stirred by the synchronised noise pin
  // an all-zero state would lock the lfsr, so it reloads the seed
  assign entropy_fb = entropy[15] ^ entropy[14] ^ entropy[12] ^ entropy[3] ^
                      noise_s2;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      entropy <= pxp_pkg::ENTROPY_SEED;
    end else if (entropy == 16'h0000) begin
      entropy <= pxp_pkg::ENTROPY_SEED;
    end else begin
      entropy <= {entropy[14:0], entropy_fb};
    end
  end

  // identification word
  always_comb begin
    variant_word = 16'h0000;
    variant_word[pxp_pkg::VAR_INDUSTRIAL] = IS_INDUSTRIAL;
    variant_word[pxp_pkg::VAR_QUAD] = IS_QUAD;
    variant_word[pxp_pkg::VAR_PTP] = HAS_PTP;
    variant_word[pxp_pkg::VAR_SECURE] = HAS_SECURE;
    variant_word[pxp_pkg::VAR_DUAL_MEDIA] = HAS_DUAL_MEDIA;
    variant_word[pxp_pkg::VAR_HI_PREC] = HAS_HI_PREC;
    variant_word[pxp_pkg::VAR_KEY256] = HAS_KEY256;
    variant_word[7:0] = VARIANT_BCD;
  end

  // read mux
  always_comb begin
    next_rdata = 16'h0000;
    next_rhit = 1'b0;
    if (reg_rd) begin
      if (reg_addr == pxp_pkg::ADDR_PAGE_SEL) begin
        next_rdata = page;
        next_rhit = 1'b1;
      end else if (on_page2) begin
        case (reg_addr)
          pxp_pkg::ADDR_LPI_CTRL: begin
            next_rdata = lpc;
            next_rdata[pxp_pkg::LPC_LINK_UP] = stat_q.link_up;
            next_rdata[pxp_pkg::LPC_LPI_1G] = stat_q.lpi_active_1g;
            next_rdata[pxp_pkg::LPC_LPI_100] = stat_q.lpi_active_100;
            next_rhit = 1'b1;
          end
          pxp_pkg::ADDR_VARIANT: begin
            next_rdata = variant_word;
            next_rhit = 1'b1;
          end
          pxp_pkg::ADDR_ENTROPY: begin
            next_rdata = entropy;
            next_rhit = 1'b1;
          end
          pxp_pkg::ADDR_EV_MASK: begin
            next_rdata = ev_mask;
            next_rhit = 1'b1;
          end
          pxp_pkg::ADDR_EV_PEND: begin
            next_rdata[pxp_pkg::EV_COUNT-1:0] = ev_pend;
            next_rhit = 1'b1;
          end
          default: begin
            next_rdata = 16'h0000;
            next_rhit = 1'b0;
          end
        endcase
      end
    end
  end

  // read answer stands for the one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_rhit <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rhit <= next_rhit;
    end
  end

  // page copy for the neighbouring banks, one cycle behind
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_sel <= pxp_pkg::PAGE_MAIN;
    end else begin
      page_sel <= page;
    end
  end

  // low power idle steering
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lpi_out <= '0;
    end else begin
      lpi_out.tx_from_generator <= lpc[pxp_pkg::LPC_FORCE_TX_LPI];
      if (lpc[pxp_pkg::LPC_FORCE_TX_LPI]) begin
        lpi_out.line_tx_lpi <= 1'b1;
      end else if (lpi_in.mode_100 && lpc[pxp_pkg::LPC_INH_100_TX]) begin
        lpi_out.line_tx_lpi <= 1'b0;
      end else if (lpi_in.mode_1g && lpc[pxp_pkg::LPC_INH_1G_TX]) begin
        lpi_out.line_tx_lpi <= 1'b0;
      end else begin
        lpi_out.line_tx_lpi <= lpi_in.mac_tx_lpi;
      end
      if (lpi_in.mode_100 && lpc[pxp_pkg::LPC_INH_100_RX]) begin
        lpi_out.mac_rx_lpi <= 1'b0;
      end else if (lpi_in.mode_1g && lpc[pxp_pkg::LPC_INH_1G_RX]) begin
        lpi_out.mac_rx_lpi <= 1'b0;
      end else begin
        lpi_out.mac_rx_lpi <= lpi_in.line_rx_lpi;
      end
    end
  end

  // energy efficient 10 Mb/s mode enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_10te <= 1'b0;
    end else begin
      en_10te <= lpc[pxp_pkg::LPC_EN_10TE];
    end
  end

  // forced gigabit only while control register 0 selects gigabit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      force_1g_no_ms <= 1'b0;
    end else begin
      force_1g_no_ms <= lpc[pxp_pkg::LPC_FORCE_1G] &&
                        (ctrl0_speed_sel == pxp_pkg::SPEED_SEL_1G);
    end
  end

  // indicators: idle level high unless the group is inverted
  // a disabled indicator sits at its inactive level, not at its last one
  assign ind_inv = lpc[pxp_pkg::LPC_INV_HI:pxp_pkg::LPC_INV_LO];
  assign ind_enable = !fiber_unidir || lpc[pxp_pkg::LPC_IND_UNIDIR];

  genvar g;
  generate
    for (g = 0; g < NIND; g++) begin : g_ind
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          indicator_outputs[g] <= 1'b1;
        end else begin
          indicator_outputs[g] <= ~(ind_req[g] && ind_enable) ^
                                  ind_inv[g / IND_PER_GROUP];
        end
      end
    end
    for (g = 0; g < IND_GROUPS; g++) begin : g_ser
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          serial_ind[g] <= 1'b1;
        end else begin
          serial_ind[g] <= ~(serial_ind_req[g] && ind_enable) ^
                           ind_inv[g];
        end
      end
    end
  endgenerate
endmodule

// *** pxp_regs_end.sv ***
// no logic here: the whole register bank stands in pxp_regs.sv

// *** pxp_regs_props.sv ***
// concurrent checks on the ports of the extended page two register bank
module pxp_regs_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rhit,
  // lpi paths and link controls
  input wire pxp_pkg::pxp_lpi_in_t lpi_in,
  input wire pxp_pkg::pxp_lpi_out_t lpi_out,
  input wire logic [1:0] ctrl0_speed_sel,
  input wire logic en_10te,
  input wire logic force_1g_no_ms,
  // events
  input wire logic [pxp_pkg::EV_COUNT-1:0] ev_in,
  input wire logic irq
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_read_quiet: assert property (
    !reg_rd |=> reg_rdata == 16'h0000 && !reg_rhit)
    else $error("read data seen without a read");
  a_page_reg_hit: assert property (
    reg_rd && reg_addr == pxp_pkg::ADDR_PAGE_SEL |=> reg_rhit)
    else $error("page select read not answered");
  a_low_addr_miss: assert property (
    reg_rd && reg_addr < pxp_pkg::ADDR_PAGED_LO |=> !reg_rhit)
    else $error("low address answered by paged bank");
  a_ten_te_mirror: assert property (
    reg_rd && reg_addr == pxp_pkg::ADDR_LPI_CTRL ##1 reg_rhit
    |-> en_10te == reg_rdata[15])
    else $error("10 Mb/s enable differs from its bit");
  a_force_gig: assert property (
    reg_rd && reg_addr == pxp_pkg::ADDR_LPI_CTRL ##1 reg_rhit
    |-> force_1g_no_ms == (reg_rdata[5] &&
    $past(ctrl0_speed_sel) == pxp_pkg::SPEED_SEL_1G))
    else $error("forced gigabit output wrong");
  a_rx_lpi_cause: assert property (
    lpi_out.mac_rx_lpi |-> $past(lpi_in.line_rx_lpi))
    else $error("mac receive lpi without line lpi");
  a_tx_lpi_cause: assert property (
    lpi_out.line_tx_lpi |->
    lpi_out.tx_from_generator || $past(lpi_in.mac_tx_lpi))
    else $error("line transmit lpi without a source");
  a_gen_sends_lpi: assert property (
    lpi_out.tx_from_generator |-> lpi_out.line_tx_lpi)
    else $error("generator active but no lpi sent");
  a_pend_reserved: assert property (
    reg_rd && reg_addr == pxp_pkg::ADDR_EV_PEND
    |=> reg_rdata[15:11] == 5'h00)
    else $error("reserved pending bits set");
  a_irq_clears: assert property (
    reg_rd && reg_addr == pxp_pkg::ADDR_EV_PEND && ev_in == '0
    ##1 reg_rhit && ev_in == '0 |=> !irq)
    else $error("irq stays after pending read");
endmodule

bind pxp_regs pxp_regs_props u_props (.mclk(mclk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rhit(reg_rhit), .lpi_in(lpi_in), .lpi_out(lpi_out),
  .ctrl0_speed_sel(ctrl0_speed_sel), .en_10te(en_10te),
  .force_1g_no_ms(force_1g_no_ms), .ev_in(ev_in), .irq(irq));

// *** pxp_tb.sv ***
// self-checking bench for the extended page two register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, soft_reset, reg_wr, reg_rd, reg_rhit, h;
  logic fiber_unidir, noise_pin, irq, en_10te, force_1g_no_ms;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, page_sel, d, e;
  logic [1:0] ctrl0_speed_sel;
  logic [7:0] ind_req, indicator_outputs;
  logic [3:0] serial_ind_req, serial_ind;
  logic [10:0] ev_in;
  logic [2:0] x;
  pxp_pkg::pxp_lpi_in_t lpi_in;
  pxp_pkg::pxp_lpi_out_t lpi_out;
  pxp_pkg::pxp_link_stat_t link_stat;
  int miscompares, samples_checked;
  logic [15:0] pins;

  assign pins = {4'h0, serial_ind, indicator_outputs};

  pxp_regs #(.IS_INDUSTRIAL(1'b1), .VARIANT_BCD(8'h27)) dut (
    .mclk(mclk), .rstn(rstn), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rhit(reg_rhit),
    .page_sel(page_sel), .lpi_in(lpi_in), .lpi_out(lpi_out),
    .link_stat(link_stat), .ctrl0_speed_sel(ctrl0_speed_sel),
    .en_10te(en_10te), .force_1g_no_ms(force_1g_no_ms),
    .ind_req(ind_req), .serial_ind_req(serial_ind_req),
    .fiber_unidir(fiber_unidir), .indicator_outputs(indicator_outputs),
    .serial_ind(serial_ind), .ev_in(ev_in), .noise_pin(noise_pin),
    .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [15:0] ex,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== ex) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, ex, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data and hit are taken in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    h = reg_rhit;
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic ev_try(input logic [15:0] m, input int i, input logic q);
    wr(pxp_pkg::ADDR_EV_MASK, m);
    ev_in <= 11'h001 << i;
    @(posedge mclk);
    ev_in <= '0;
    @(posedge mclk);
    #1;
    chk("irq", {15'h0, q}, {15'h0, irq});
    rd(pxp_pkg::ADDR_EV_PEND);
    chk("pending", 16'h0001 << i, d);
    @(posedge mclk);
    #1;
    chk("irq after read", 16'h0000, {15'h0, irq});
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    test_done;
  end

  initial begin
    rstn = 1'b0;
    soft_reset = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lpi_in = '0;
    link_stat = '0;
    ctrl0_speed_sel = 2'b10;
    ind_req = 8'h0f;
    serial_ind_req = 4'h5;
    fiber_unidir = 1'b0;
    ev_in = '0;
    noise_pin = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    #1;
    chk("pins in reset", 16'h0fff, pins);
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(5'h1f, pxp_pkg::PAGE_EXT2);
    rd(pxp_pkg::ADDR_LPI_CTRL);
    chk("lpc reset", 16'h0000, d);
    chk("page_sel", pxp_pkg::PAGE_EXT2, page_sel);
    rd(pxp_pkg::ADDR_EV_MASK);
    chk("mask reset", 16'h0000, d);
    wr(pxp_pkg::ADDR_EV_MASK, 16'hffff);
    rd(pxp_pkg::ADDR_EV_MASK);
    chk("mask all", 16'hffff, d);
    wr(pxp_pkg::ADDR_VARIANT, 16'h0000);
    wr(pxp_pkg::ADDR_EV_PEND, 16'hffff);
    rd(pxp_pkg::ADDR_VARIANT);
    chk("variant", {8'hb5, 8'h27}, d);
    rd(pxp_pkg::ADDR_EV_PEND);
    chk("pending ro", 16'h0000, d);
    rd(pxp_pkg::ADDR_ENTROPY);
    e = d;
    rd(pxp_pkg::ADDR_ENTROPY);
    chk("entropy moves", 16'h0001, {15'h0, d !== e});
    $display("test reset values done");
    wr(pxp_pkg::ADDR_LPI_CTRL, 16'hffff);
    link_stat <= 3'b101;
    rd(pxp_pkg::ADDR_LPI_CTRL);
    chk("lpc all", 16'hfd7f, d);
    chk("ctl outs", 16'h0003, {14'h0, en_10te, force_1g_no_ms});
    chk("pins inv", 16'h050f, pins);
    @(posedge mclk);
    fiber_unidir <= 1'b1;
    ctrl0_speed_sel <= 2'b01;
    settle;
    chk("pins unidir on", 16'h050f, pins);
    chk("force other speed", 16'h0000, {15'h0, force_1g_no_ms});
    wr(pxp_pkg::ADDR_LPI_CTRL, 16'h0000);
    settle;
    chk("pins unidir off", 16'h0fff, pins);
    @(posedge mclk);
    fiber_unidir <= 1'b0;
    settle;
    chk("pins low", 16'h0af0, pins);
    $display("test controls done");
    rd(5'h05);
    chk("low addr", 16'h0000, {15'h0, h});
    wr(5'h1f, pxp_pkg::PAGE_MAIN);
    rd(pxp_pkg::ADDR_LPI_CTRL);
    chk("main page", 16'h0000, {d[15:1], h});
    wr(5'h1f, pxp_pkg::PAGE_EXT2);
    wr(pxp_pkg::ADDR_LPI_CTRL, 16'h8000);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    rd(5'h1f);
    chk("page soft", 16'h0000, d);
    chk("page_sel soft", pxp_pkg::PAGE_MAIN, page_sel);
    wr(5'h1f, pxp_pkg::PAGE_EXT2);
    rd(pxp_pkg::ADDR_LPI_CTRL);
    chk("sticky", 16'h8140, d);
    $display("test paging done");
    for (int k = 0; k < 256; k++) begin
      wr(pxp_pkg::ADDR_LPI_CTRL, {11'h0, k[4:0]});
      lpi_in <= {k[6], k[5], k[7], k[7]};
      settle;
      x[2] = k[4] | (k[7] & !((k[5] & k[3]) | (k[6] & k[1])));
      x[1] = k[4];
      x[0] = k[7] & !((k[5] & k[2]) | (k[6] & k[0]));
      chk("lpi out", {13'h0, x}, {13'h0, lpi_out});
    end
    $display("test lpi paths done");
    for (int i = 0; i < 11; i++) begin
      ev_try(~(16'h0001 << i), i, 1'b0);
      ev_try(16'h0001 << i, i, 1'b1);
    end
    $display("test events done");
    test_done;
  end
endmodule
